/* verilog/gplcd_port.v */
/*
  Four-pin general-purpose port shared with LCD segment outputs.
  Holds data latch, direction, and control registers; drives pins
  as output / enable / input triples.
  Assumes a plain register port on mclk_i, pins from outside the
  clock domain, and an LCD controller on the same clock.
*/
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "gplcd_consts.vh"

// How it works
// [RL1] Direction bit one makes pin drive
// [RL2] Direction bit zero makes pin input
// [RL3] Output pin drives its latch bit
// [RL4] Data write updates latch, shown on the pin one clock later
// [RL5] Input pins latch written data, undriven
// [RL6] Normal read of output pins: latch
// [RL7] Input pins read level; READ_MODIFY_WRITE reads latch
// [RL8] Zero is low, one is high
// [RL9] Software selects port, then sets control
// [RL10] Segment select plus control routes segment; here only on pins whose direction bit is zero
// [RL11] Reset clears every direction bit
// [RL12] Standby with setting bit floats pins
// [RL13] Floating pins block input, held low
// [RL14] Setting bit zero keeps pins unchanged
// [RL15] Software disables peripheral before port use
// [RL16] Four pins on bits zero to three
// [RL17] Upper bits read zero, ignore writes
module gplcd_port #(
  parameter N = `GPLCD_PINS          // Pin count
) (
  input  wire                     mclk_i,      // 40 MHz clock
  input  wire                     rst_i,       // Sync reset
  input  wire [`GPLCD_ADDR_W-1:0] addr_i,      // Register index
  input  wire [`GPLCD_DATA_W-1:0] wdata_i,     // Write data
  input  wire                     wr_i,        // Write strobe
  input  wire                     rd_i,        // Read strobe
  input  wire                     rmw_i,       // Read is part of READ_MODIFY_WRITE
  output reg  [`GPLCD_DATA_W-1:0] rdata_o,     // Read data
  input  wire                     standby_i,   // Stop or watch mode
  input  wire [N-1:0]             seg_i,       // LCD segment drive
  input  wire [N-1:0]             pin_i,       // Pin levels
  output reg  [N-1:0]             pin_o,       // Pin drive level
  output reg  [N-1:0]             pin_oe_o,    // Pin drive enable
  output reg  [N-1:0]             pin_in_o     // Gated input path
);
  reg  [N-1:0] latch_q;              // Output data latch
  reg  [N-1:0] dir_q;                // Direction, 1 = output
  reg  [N-1:0] seg_sel_q;            // Segment function select
  reg          pic_q;                // Port input control
  reg          spl_q;                // Pin state setting
  reg  [N-1:0] latch_d;              // Next latch value
  reg  [N-1:0] dir_d;                // Next direction value
  wire [N-1:0] pin_sync;             // Synchronised pins
  wire [N-1:0] out_d;                // Next pin level
  wire [N-1:0] oe_d;                 // Next pin enable
  wire [N-1:0] in_d;                 // Next gated input
  wire         hiz;                  // Standby float request
  reg  [`GPLCD_DATA_W-1:0] rdata_d;  // Next read data

  // Pad to the 8-bit bus; upper lanes read as zero
  function [`GPLCD_DATA_W-1:0] pad;
    input [N-1:0] v;
    begin
      pad = {{(`GPLCD_DATA_W-N){1'b0}}, v};               // [RL17]
    end
  endfunction

  // Pins are asynchronous to mclk_i
  gplcd_sync #(
    .W       (N)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  // Float only when setting bit is set; otherwise hold state
  assign hiz = standby_i & spl_q;                         // [RL12] [RL14]

  gplcd_pinmux #(
    .N          (N)
  ) u_mux (
    .latch_i    (latch_q),
    .dir_i      (dir_q),
    .seg_sel_i  (seg_sel_q),
    .pic_i      (pic_q),
    .seg_i      (seg_i),
    .hiz_i      (hiz),
    .pin_sync_i (pin_sync),
    .out_o      (out_d),
    .oe_o       (oe_d),
    .in_o       (in_d)
  );

  // Write decode for latch and direction
  always @* begin
    latch_d = latch_q;
    dir_d   = dir_q;
    if (wr_i && addr_i == `GPLCD_REG_DATA) begin
      // All four bits stored, driven or not
      latch_d = wdata_i[N-1:0];                           // [RL4] [RL5]
    end
    if (wr_i && addr_i == `GPLCD_REG_DIR) begin
      dir_d = wdata_i[N-1:0];                             // [RL16]
    end
  end

  // Register state
  always @(posedge mclk_i) begin
    if (rst_i) begin
      latch_q   <= `GPLCD_LATCH_RST;
      dir_q     <= `GPLCD_DIR_RST;                        // [RL11]
      seg_sel_q <= `GPLCD_SEL_RST;
      pic_q     <= 1'b0;
      spl_q     <= 1'b0;
    end else begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
      if (wr_i && addr_i == `GPLCD_REG_CTRL) begin
        // Select and control taken from the same CTRL write, so they change together
        seg_sel_q <= wdata_i[`GPLCD_CTRL_SEL_LSB +: N];   // [RL10]
        pic_q     <= wdata_i[`GPLCD_CTRL_PIC_BIT];
        spl_q     <= wdata_i[`GPLCD_CTRL_SPL_BIT];
      end
    end
  end

  // Read mux; input pins show level unless read is READ_MODIFY_WRITE
  always @* begin
    rdata_d = {`GPLCD_DATA_W{1'b0}};
    case (addr_i)
      `GPLCD_REG_DATA: begin
        if (rmw_i) begin
          rdata_d = pad(latch_q);                         // [RL7]
        end else begin
          rdata_d = pad((dir_q & latch_q) |
                        (~dir_q & in_d));                 // [RL6] [RL7]
        end
      end
      `GPLCD_REG_DIR:  rdata_d = pad(dir_q);              // [RL17]
      `GPLCD_REG_CTRL: begin
        rdata_d = {{(`GPLCD_DATA_W-6){1'b0}}, spl_q, pic_q, seg_sel_q};
      end
      `GPLCD_REG_STAT: rdata_d = pad(pin_sync);
      default:         rdata_d = {`GPLCD_DATA_W{1'b0}};
    endcase
  end

  // Outputs from flops; read data stands one cycle after strobe
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o  <= {`GPLCD_DATA_W{1'b0}};
      pin_o    <= {N{1'b0}};
      pin_oe_o <= {N{1'b0}};                              // [RL11]
      pin_in_o <= {N{1'b0}};
    end else begin
      rdata_o  <= rd_i ? rdata_d : {`GPLCD_DATA_W{1'b0}};
      pin_o    <= out_d;                                  // [RL4]
      pin_oe_o <= oe_d;
      pin_in_o <= in_d;                                   // [RL13]
    end
  end
endmodule // gplcd_port

/* verilog/gplcd_consts.vh */
/*
  Constants for the four-pin port shared with LCD segment outputs:
  register indices, field positions, reset values.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef GPLCD_CONSTS_VH
`define GPLCD_CONSTS_VH

// Register indices on the plain register port
`define GPLCD_ADDR_W        2
`define GPLCD_REG_DATA      2'h0
`define GPLCD_REG_DIR       2'h1
`define GPLCD_REG_CTRL      2'h2
`define GPLCD_REG_STAT      2'h3

// Port geometry
`define GPLCD_PINS          4
`define GPLCD_DATA_W        8

// Reset values
`define GPLCD_DIR_RST       4'h0
`define GPLCD_LATCH_RST     4'h0
`define GPLCD_SEL_RST       4'h0

// Control register fields
`define GPLCD_CTRL_SEL_LSB  0
`define GPLCD_CTRL_PIC_BIT  4
`define GPLCD_CTRL_SPL_BIT  5

`endif

/* verilog/gplcd_sync.v */
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes one clock domain, synchronous active-high reset.
*/
`timescale 1ns/100ps
module gplcd_sync #(
  parameter W = 4                    // Number of bits
) (
  input  wire         mclk_i,        // Clock
  input  wire         rst_i,         // Sync reset
  input  wire [W-1:0] async_i,       // Raw pin levels
  output reg  [W-1:0] sync_o         // Synchronised levels
);
  reg [W-1:0] meta_q;                // First stage, read only by sync_o

  // Two stages; first stage feeds nothing else
  always @(posedge mclk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // gplcd_sync

/* verilog/gplcd_pinmux.v */
/*
  Per-pin multiplexer: chooses port latch or LCD segment drive,
  and applies the standby high-impedance force and input block.
  Purely combinational; registered by the top.
*/
`timescale 1ns/100ps
module gplcd_pinmux #(
  parameter N = 4                    // Pin count
) (
  input  wire [N-1:0] latch_i,       // Output latch
  input  wire [N-1:0] dir_i,         // Direction, 1 = output
  input  wire [N-1:0] seg_sel_i,     // 1 = LCD segment function
  input  wire         pic_i,         // Port input control
  input  wire [N-1:0] seg_i,         // Segment drive from LCD
  input  wire         hiz_i,         // Standby force high-Z
  input  wire [N-1:0] pin_sync_i,    // Synchronised pin levels
  output reg  [N-1:0] out_o,         // Next pin output level
  output reg  [N-1:0] oe_o,          // Next pin output enable
  output reg  [N-1:0] in_o           // Gated input path
);
  integer k;

  // One pass per pin
  always @* begin
    out_o = {N{1'b0}};
    oe_o  = {N{1'b0}};
    in_o  = {N{1'b0}};
    for (k = 0; k < N; k = k + 1) begin
      if (hiz_i) begin
        // Floating pin: driver off, input held low
        out_o[k] = 1'b0;                               // [RL12]
        oe_o[k]  = 1'b0;                               // [RL12]
        in_o[k]  = 1'b0;                               // [RL13]
      end else if (seg_sel_i[k] && pic_i && !dir_i[k]) begin
        // Segment owns the pin
        out_o[k] = seg_i[k];                           // [RL10]
        oe_o[k]  = 1'b1;                               // [RL10]
        in_o[k]  = pin_sync_i[k];
      end else begin
        out_o[k] = latch_i[k];                         // [RL3] [RL8]
        oe_o[k]  = dir_i[k];                           // [RL1] [RL2]
        in_o[k]  = pin_sync_i[k];                      // [RL8]
      end
    end
  end
endmodule // gplcd_pinmux

/* testbench/gplcd_port_checker.sv */
/* Checker for the LCD-shared port: pin drive, float, read data.
   Assumes binding to gplcd_port with N of 4. */
`timescale 1ns/100ps
module gplcd_port_checker (
  input wire       mclk_i,
  input wire       rst_i,
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire       rmw_i,
  input wire [7:0] rdata_o,
  input wire       standby_i,
  input wire [3:0] seg_i,
  input wire [3:0] pin_i,
  input wire [3:0] pin_o,
  input wire [3:0] pin_oe_o,
  input wire [3:0] pin_in_o
);
  reg  [3:0] dir_q;  // Shadow direction
  reg  [3:0] lat_q;  // Shadow latch
  reg  [5:0] ctl_q;  // Shadow control
  wire       hiz = standby_i & ctl_q[5];
  wire [3:0] sg = ctl_q[3:0] & ~dir_q & {4{ctl_q[4]}};
  wire [3:0] oe_x = hiz ? 4'h0 : (dir_q | sg);
  wire [3:0] out_x = hiz ? 4'h0 : ((dir_q & lat_q) | (sg & seg_i));
  // Shadows drop bits with no pin, as the port must
  always @(posedge mclk_i) begin
    if (rst_i) begin
      dir_q <= 4'h0;
      lat_q <= 4'h0;
      ctl_q <= 6'h00;
    end else if (wr_i) begin
      if (addr_i == 2'h0) lat_q <= wdata_i[3:0];
      if (addr_i == 2'h1) dir_q <= wdata_i[3:0];
      if (addr_i == 2'h2) ctl_q <= wdata_i[5:0];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_data_rd;
    rd_i && addr_i == 2'h0;
  endsequence
  a_dir_drive: assert property (
    (pin_oe_o & $past(dir_q)) == ($past(oe_x) & $past(dir_q)))
    else $error("output pin not driven");
  a_input_off: assert property (
    (pin_oe_o & ~$past(dir_q | sg)) == 4'h0)
    else $error("input pin driven");
  a_latch_level: assert property (
    (pin_o & $past(dir_q)) == ($past(out_x) & $past(dir_q)))
    else $error("pin level differs from latch");
  a_seg_route: assert property (
    (pin_o & $past(sg)) == ($past(out_x) & $past(sg)))
    else $error("segment not routed");
  a_float_pins: assert property (
    $past(hiz) |-> pin_oe_o == 4'h0 && pin_o == 4'h0)
    else $error("pins not floated");
  a_input_block: assert property (
    $past(hiz) |-> pin_in_o == 4'h0)
    else $error("input path not blocked");
  a_hold_state: assert property (
    $past(standby_i) && !$past(ctl_q[5]) |-> pin_oe_o == $past(dir_q | sg))
    else $error("pins changed in standby");
  a_read_out: assert property (
    s_data_rd |=> (rdata_o[3:0] & $past(dir_q)) == $past(lat_q & dir_q))
    else $error("output bits read wrong");
  a_read_rmw: assert property (
    s_data_rd ##0 rmw_i |=> rdata_o == {4'h0, $past(lat_q)})
    else $error("rmw read not latch");
  a_upper_zero: assert property (
    rd_i && !addr_i[1] |=> rdata_o[7:4] == 4'h0)
    else $error("upper bits not zero");
endmodule // gplcd_port_checker
bind gplcd_port gplcd_port_checker u_chk (.mclk_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rmw_i, .rdata_o, .standby_i, .seg_i, .pin_i,
  .pin_o, .pin_oe_o, .pin_in_o);

/* testbench/gplcd_far_model.sv */
/* Far side of the port: board drivers and the segment source.
   Assumes the port's clock; undriven pins churn, no pull. */
`timescale 1ns/100ps
module gplcd_far_model #(
  parameter SEG = 4'h6              // Segment pattern
) (
  input  wire       mclk_i,         // Clock
  input  wire [3:0] pin_o,          // Port drive level
  input  wire [3:0] pin_oe_o,       // Port drive enable
  input  wire [3:0] ext_i,          // Board drive level
  input  wire [3:0] ext_en_i,       // Board drive enable
  output wire [3:0] pin_i,          // Resolved pin level
  output wire [3:0] seg_o           // Segment drive
);
  reg [3:0] spin_q = 4'h5;          // Floating lines wander
  assign seg_o = SEG;
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_i)
               | (~pin_oe_o & ~ext_en_i & spin_q);
  always @(posedge mclk_i) spin_q <= ~spin_q;
endmodule // gplcd_far_model

/* testbench/gplcd_port_test.sv */
/* Testbench for gplcd_port: register tasks and pin checks.
   Assumes the far model and the bound checker. */
`timescale 1ns/100ps
module gplcd_port_test;
  reg        mclk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg  [1:0] addr_i = 2'h0;
  reg  [7:0] wdata_i = 8'h00;
  reg        wr_i = 1'b0;
  reg        rd_i = 1'b0;
  reg        rmw_i = 1'b0;
  reg        standby_i = 1'b0;
  reg  [3:0] ext = 4'h2;
  reg  [3:0] ext_en = 4'h0;
  wire [3:0] seg, pin_i, pin_o, pin_oe_o, pin_in_o;
  wire [7:0] rdata_o;
  integer    mismatches = 0;
  integer    check_count = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  gplcd_port uut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rmw_i, .rdata_o, .standby_i, .seg_i(seg), .pin_i, .pin_o,
    .pin_oe_o, .pin_in_o);
  gplcd_far_model far (.mclk_i, .pin_o, .pin_oe_o, .ext_i(ext),
    .ext_en_i(ext_en), .pin_i, .seg_o(seg));
  task check(input [63:0] nm, input [7:0] ex, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== ex) begin
        mismatches = mismatches + 1;
        $display("Error %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge mclk_i);
      #1;
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      tick(1);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, input m, input [7:0] ex, input [63:0] nm);
    begin
      addr_i <= a;
      rmw_i <= m;
      rd_i <= 1'b1;
      tick(1);
      rd_i <= 1'b0;
      rmw_i <= 1'b0;
      check(nm, ex, rdata_o);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #200000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial begin
    tick(16);
    rst_i <= 1'b0;
    ext_en <= 4'hA;
    tick(1);
    rd(2'h1, 1'b0, 8'h00, "dir");
    wr(2'h0, 8'hFF);
    wr(2'h1, 8'hF5);
    rd(2'h1, 1'b0, 8'h05, "dir");
    check("oe", 8'h05, {4'h0, pin_oe_o});
    check("pin", 8'h05, {4'h0, pin_o & 4'h5});
    tick(2);
    rd(2'h0, 1'b0, 8'h07, "data");
    rd(2'h0, 1'b1, 8'h0F, "rmw");
    rd(2'h3, 1'b0, 8'h07, "stat");
    wr(2'h0, 8'h0A);
    rd(2'h0, 1'b0, 8'h02, "data");
    check("pin", 8'h00, {4'h0, pin_o & 4'h5});
    ext_en <= 4'h0;
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h1F);
    rd(2'h2, 1'b0, 8'h1F, "ctrl");
    tick(1);
    check("segoe", 8'h0F, {4'h0, pin_oe_o});
    check("seg", 8'h06, {4'h0, pin_o});
    wr(2'h2, 8'h10);
    tick(2);
    check("portoe", 8'h00, {4'h0, pin_oe_o});
    wr(2'h1, 8'h0F);
    wr(2'h2, 8'h30);
    standby_i <= 1'b1;
    tick(3);
    check("hiz", 8'h00, {pin_oe_o, pin_o});
    check("inblk", 8'h00, {4'h0, pin_in_o});
    wr(2'h2, 8'h10);
    tick(2);
    check("hold", 8'hFA, {pin_oe_o, pin_o});
    standby_i <= 1'b0;
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    rd(2'h1, 1'b0, 8'h00, "dir");
    check("rstoe", 8'h00, {4'h0, pin_oe_o});
    conclude;
  end
endmodule // gplcd_port_test
